// ===== include/gdcf_defines.svh
//--------------------------------------------------------------------
// Overview of operation
// - Push request stores one word each edge
// - Pop request removes word, advances head
// - Option: fall-through or registered pop word
// - Read side occupancy count, zero after reset
// - Write side free count, starts at capacity
// - No-words flag leads the occupancy count
// - No-space flag leads the free count
// - Depth from address bits, separate width
// - Option: Gray-crossed or direct pointer views, one shared clock
// - Option: storage style label, same array either way
// - Counts derived from read/write pointers
// - One reset clears pointers and read count, sets free count to capacity
// - No overflow or underflow reporting
//--------------------------------------------------------------------
`ifndef GDCF_DEFINES_SVH
`define GDCF_DEFINES_SVH

//--------------------------------------------------------------------
// Geometry
//--------------------------------------------------------------------
`define GDCF_ADDR_BITS     4
`define GDCF_DATA_BITS     32
`define GDCF_DEPTH         (1 << `GDCF_ADDR_BITS)
`define GDCF_SKID_DEPTH    2

//--------------------------------------------------------------------
// APB register map
//--------------------------------------------------------------------
`define GDCF_APB_AW        12
`define GDCF_CTRL_OFS      12'h000
`define GDCF_STATUS_OFS    12'h004
`define GDCF_LEVELS_OFS    12'h008

// Field positions
`define GDCF_CTRL_HOLD_BIT     0
`define GDCF_CTRL_RESET        32'h0000_0000
`define GDCF_ST_EMPTY_BIT      0
`define GDCF_ST_FULL_BIT       1
`define GDCF_ST_BUF_VALID_BIT  2
`define GDCF_ST_BUF_READY_BIT  3
`define GDCF_LV_RD_LSB         0
`define GDCF_LV_WR_LSB         16

`endif

// ===== include/gdcf_pkg.sv
`include "gdcf_defines.svh"

package gdcf_pkg;

    //----------------------------------------------------------------
    // Widths and types
    //----------------------------------------------------------------
    localparam int AW = `GDCF_ADDR_BITS;
    localparam int DW = `GDCF_DATA_BITS;
    localparam int DEPTH = `GDCF_DEPTH;

    typedef logic [AW:0]    gdcf_ptr_t;   // Pointer with wrap bit
    typedef logic [DW-1:0]  gdcf_word_t;

    // Full capacity in words, at pointer width
    localparam gdcf_ptr_t CAPACITY = gdcf_ptr_t'(DEPTH);

    // Whole state of the FIFO top
    typedef struct packed {
        gdcf_word_t [DEPTH-1:0] mem;      // Storage array
        gdcf_ptr_t              wptr;     // Binary write pointer
        gdcf_ptr_t              rptr;     // Binary read pointer
        gdcf_ptr_t              wgray;    // Registered Gray copies
        gdcf_ptr_t              rgray;
        gdcf_ptr_t              wg_s1;    // Synchroniser stages
        gdcf_ptr_t              wg_s2;
        gdcf_ptr_t              rg_s1;
        gdcf_ptr_t              rg_s2;
        logic                   empty;
        logic                   full;
        gdcf_ptr_t              rd_level;
        gdcf_ptr_t              wr_level;
        gdcf_word_t             rd_data;
        logic                   hold;     // Software hold of buffer drain
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } gdcf_state_s;

    // Whole state of the two-entry buffer
    typedef struct packed {
        gdcf_word_t [`GDCF_SKID_DEPTH-1:0] ent;
        logic [1:0]                        cnt;
        logic                              rdy;
    } gdcf_skid_s;

    //----------------------------------------------------------------
    // Gray code helpers
    //----------------------------------------------------------------
    function automatic gdcf_ptr_t gdcf_b2g(input gdcf_ptr_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic gdcf_ptr_t gdcf_g2b(input gdcf_ptr_t g);
        gdcf_ptr_t b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ===== core/gdcf_skid.sv
`timescale 1ns/1ps
`include "gdcf_defines.svh"

// Two-entry buffer: a stall downstream loses no word
module gdcf_skid
    import gdcf_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Filling side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire gdcf_word_t in_data,
    // Draining side
    output logic            out_valid,
    input  wire logic       out_ready,
    output gdcf_word_t      out_data
);

    gdcf_skid_s s_reg;    // Current state
    gdcf_skid_s s_next;   // Next state

    logic take;           // Word accepted this cycle
    logic give;           // Word drained this cycle

    assign in_ready  = s_reg.rdy;
    assign out_valid = (s_reg.cnt != 2'h0);
    assign out_data  = s_reg.ent[0];

    //----------------------------------------------------------------
    // Next state
    //----------------------------------------------------------------
    // Entry 0 is always the head, so the output needs no mux
    always_comb begin
        s_next = s_reg;
        take   = in_valid & s_reg.rdy;
        give   = out_valid & out_ready;
        if (give) begin
            s_next.ent[0] = s_reg.ent[1];
        end
        if (take) begin
            // Slot after the drain has happened
            if (s_reg.cnt - 2'(give) == 2'h0) begin
                s_next.ent[0] = in_data;
            end else begin
                s_next.ent[1] = in_data;
            end
        end
        s_next.cnt = s_reg.cnt + 2'(take) - 2'(give);
        // Ready from a flop keeps the long path out of the source
        s_next.rdy = (s_next.cnt != 2'(`GDCF_SKID_DEPTH));
    end

    //----------------------------------------------------------------
    // State register
    //----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

// ===== core/gdcf_top.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "gdcf_defines.svh"

// Generic FIFO with word counts and an APB status/control port
module gdcf_top
    import gdcf_pkg::*;
#(
    parameter bit FALL_THROUGH = 1'b1,  // Head word shown before pop
    parameter bit INDEP_CLK    = 1'b0,  // Counts via Gray crossing
    parameter bit USE_BRAM     = 1'b0   // Storage style, same behaviour
)
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Write side
    input  wire logic                   wr_en,
    input  wire gdcf_word_t             wr_data,
    output logic                        wr_ready,
    output logic                        wr_full,
    output gdcf_ptr_t                   wr_level,
    // Read side
    input  wire logic                   rd_en,
    output gdcf_word_t                  rd_data,
    output logic                        rd_empty,
    output gdcf_ptr_t                   rd_level,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`GDCF_APB_AW-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr
);

    //----------------------------------------------------------------
    // Declarations
    //----------------------------------------------------------------
    gdcf_state_s s_reg;      // Current state
    gdcf_state_s s_next;     // Next state

    logic        buf_valid;  // Buffer holds a word
    logic        buf_ready;  // Buffer can accept (registered)
    gdcf_word_t  buf_data;   // Buffer head word
    logic        store;      // Word moves into storage
    logic        pop;        // Head word leaves storage
    logic        access;     // APB access phase
    logic [31:0] rd_mux;     // Register read value
    logic        mapped;     // Address hits a register

    // Storage style option
    // Storage style is only a label that nothing reads; the array and its timing
    // are the same either way so behaviour cannot differ
    localparam bit STORAGE_IS_BRAM = USE_BRAM;

    //----------------------------------------------------------------
    // Input buffer
    //----------------------------------------------------------------
    // Accept pushed word
    gdcf_skid u_skid (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (wr_en),
        .in_ready  (buf_ready),
        .in_data   (wr_data),
        .out_valid (buf_valid),
        .out_ready (store),
        .out_data  (buf_data)
    );

    //----------------------------------------------------------------
    // Pointer views across the crossing
    //----------------------------------------------------------------
    // Clock option picks pointer view
    // Write pointer as the read side sees it
    function automatic gdcf_ptr_t wr_seen(input gdcf_state_s st);
        return INDEP_CLK ? gdcf_g2b(st.wg_s2) : st.wptr;
    endfunction

    // Read pointer as the write side sees it
    function automatic gdcf_ptr_t rd_seen(input gdcf_state_s st);
        return INDEP_CLK ? gdcf_g2b(st.rg_s2) : st.rptr;
    endfunction

    //----------------------------------------------------------------
    // Register read mux
    //----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `GDCF_CTRL_OFS: begin
                rd_mux[`GDCF_CTRL_HOLD_BIT] = s_reg.hold;
            end
            `GDCF_STATUS_OFS: begin
                rd_mux[`GDCF_ST_EMPTY_BIT]     = s_reg.empty;
                rd_mux[`GDCF_ST_FULL_BIT]      = s_reg.full;
                rd_mux[`GDCF_ST_BUF_VALID_BIT] = buf_valid;
                rd_mux[`GDCF_ST_BUF_READY_BIT] = buf_ready;
            end
            `GDCF_LEVELS_OFS: begin
                rd_mux[`GDCF_LV_RD_LSB +: AW+1] = s_reg.rd_level;
                rd_mux[`GDCF_LV_WR_LSB +: AW+1] = s_reg.wr_level;
            end
            default: begin
                // Unmapped: zero data and an error answer
                mapped = 1'b0;
            end
        endcase
    end

    //----------------------------------------------------------------
    // Next state
    //----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // Drain the buffer unless storage is full or software holds it;
        // the hold lets the buffer fill and back-pressure the producer
        store  = buf_valid & ~s_reg.full & ~s_reg.hold;
        // No error report; empty pop is simply ignored
        pop    = rd_en & ~s_reg.empty;

        if (store) begin
            s_next.mem[s_reg.wptr[AW-1:0]] = buf_data;
            s_next.wptr = s_reg.wptr + 1'b1;
        end
        if (pop) begin
            s_next.rptr = s_reg.rptr + 1'b1;
        end

        s_next.wgray = gdcf_b2g(s_next.wptr);
        s_next.rgray = gdcf_b2g(s_next.rptr);
        s_next.wg_s1 = s_reg.wgray;
        s_next.wg_s2 = s_reg.wg_s1;
        s_next.rg_s1 = s_reg.rgray;
        s_next.rg_s2 = s_reg.rg_s1;

        s_next.empty = (wr_seen(s_next) == s_next.rptr);
        s_next.full  = ((s_next.wptr - rd_seen(s_next)) == CAPACITY);

        // Counts from pointers, one cycle behind the flags
        s_next.rd_level = wr_seen(s_reg) - s_reg.rptr;
        s_next.wr_level = CAPACITY - (s_reg.wptr - rd_seen(s_reg));

        if (FALL_THROUGH) begin
            s_next.rd_data = s_next.mem[s_next.rptr[AW-1:0]];
        end else if (pop) begin
            s_next.rd_data = s_reg.mem[s_reg.rptr[AW-1:0]];
        end

        // APB: one wait state, answer registered
        access = psel & penable;
        if (access & ~s_reg.pready) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = ~mapped;
            s_next.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            s_next.pready  = 1'b0;
            s_next.pslverr = 1'b0;
        end
        // Write takes effect on the completing edge only
        if (access & s_reg.pready & pwrite & pstrb[0] &
            (paddr == `GDCF_CTRL_OFS)) begin
            s_next.hold = pwdata[`GDCF_CTRL_HOLD_BIT];
        end
    end

    //----------------------------------------------------------------
    // State register
    //----------------------------------------------------------------
    // Reset clears pointers and read count, sets free count to capacity
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg          <= '0;
            s_reg.empty    <= 1'b1;
            s_reg.wr_level <= CAPACITY;
            s_reg.hold     <= 1'(`GDCF_CTRL_RESET >> `GDCF_CTRL_HOLD_BIT);
        end else begin
            s_reg <= s_next;
        end
    end

    //----------------------------------------------------------------
    // Outputs, all straight from flops
    //----------------------------------------------------------------
    assign wr_ready = buf_ready;
    assign wr_full  = s_reg.full;
    assign wr_level = s_reg.wr_level;
    assign rd_data  = s_reg.rd_data;
    assign rd_empty = s_reg.empty;
    assign rd_level = s_reg.rd_level;
    assign prdata   = s_reg.prdata;
    assign pready   = s_reg.pready;
    assign pslverr  = s_reg.pslverr;

endmodule

// ===== test/gdcf_monitor.sv
`timescale 1ns/1ps
`include "gdcf_defines.svh"
//------------------------
// Port checker
//------------------------
module gdcf_monitor
    import gdcf_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // FIFO sides
    input wire logic       wr_full,
    input wire gdcf_ptr_t  wr_level,
    input wire logic       rd_en,
    input wire gdcf_word_t rd_data,
    input wire logic       rd_empty,
    input wire gdcf_ptr_t  rd_level,
    // APB answer
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [`GDCF_APB_AW-1:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr
);
    // One clock domain, all checks muted in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    empty_lead_a: assert property (1 |=> (rd_level == '0) == $past(rd_empty))
        else $error("empty flag does not lead level");
    full_lead_a: assert property (1 |=> (wr_level == '0) == $past(wr_full))
        else $error("full flag does not lead level");
    cap_bound_a: assert property (rd_level <= CAPACITY && wr_level <= CAPACITY)
        else $error("level above capacity");
    first_word_a: assert property ($fell(rd_empty) |=> rd_level == 5'h1)
        else $error("level after first word");
    head_hold_a: assert property (!rd_empty && !rd_en |=> !rd_empty && $stable(rd_data))
        else $error("head word moved without pop");
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait");
    apb_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("answer not a single pulse");
    // Error answer exactly for addresses outside the three registers
    apb_err_a: assert property (pready |-> pslverr == (paddr != `GDCF_CTRL_OFS &&
        paddr != `GDCF_STATUS_OFS && paddr != `GDCF_LEVELS_OFS))
        else $error("error flag wrong for address");

    // Main scenarios reached
    cover property (wr_full);
    cover property (pready && pslverr);
    cover property (rd_en && !rd_empty);
endmodule

bind gdcf_top gdcf_monitor u_mon (.clk(clk), .nrst(nrst), .wr_full(wr_full),
    .wr_level(wr_level), .rd_en(rd_en), .rd_data(rd_data), .rd_empty(rd_empty),
    .rd_level(rd_level), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr));

// ===== test/gdcf_sink.sv
`timescale 1ns/1ps
// Consumer on the read side
module gdcf_sink (
    // Pace from the bench
    input  wire logic go,
    // FIFO read side
    input  wire logic rd_empty,
    output logic      rd_en
);
    // No pop when empty
    // Go low models a slow consumer; never pops a missing word
    assign rd_en = go & ~rd_empty;
endmodule

// ===== test/gdcf_top_tb.sv
`timescale 1ns/1ps
`include "gdcf_defines.svh"
module gdcf_top_tb
    import gdcf_pkg::*;
;
    logic       clk, nrst, wr_en, wr_ready, wr_full, rd_en, rd_empty, go, e;
    logic       psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    gdcf_word_t wr_data, rd_data;
    gdcf_ptr_t  wr_level, rd_level;
    int         fails, cmp_count, prate, crate;
    gdcf_word_t q[$];   // Words pushed, oldest first
    // Second build: registered read, Gray crossing, block storage
    logic       b_wr_en, b_rdy, b_full, b_empty, b_rd_en, b_pend;
    gdcf_word_t b_data, b_rd_data, b_exp;
    gdcf_ptr_t  b_wl, b_rl;
    gdcf_word_t bq[$];  // Words pushed into the second build

    gdcf_top uut (.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_data(wr_data),
        .wr_ready(wr_ready), .wr_full(wr_full), .wr_level(wr_level), .rd_en(rd_en),
        .rd_data(rd_data), .rd_empty(rd_empty), .rd_level(rd_level), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    gdcf_sink u_sink (.go(go), .rd_empty(rd_empty), .rd_en(rd_en));
    gdcf_top #(.FALL_THROUGH(1'b0), .INDEP_CLK(1'b1), .USE_BRAM(1'b1)) uut_b (
        .clk(clk), .nrst(nrst), .wr_en(b_wr_en), .wr_data(b_data), .wr_ready(b_rdy),
        .wr_full(b_full), .wr_level(b_wl), .rd_en(b_rd_en), .rd_data(b_rd_data),
        .rd_empty(b_empty), .rd_level(b_rl), .psel(1'b0), .penable(1'b0),
        .pwrite(1'b0), .paddr(12'h000), .pwdata(32'h0), .pstrb(4'h0), .prdata(),
        .pready(), .pslverr());
    gdcf_sink u_sink_b (.go(go), .rd_empty(b_empty), .rd_en(b_rd_en));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, s, x);
        end
    endtask

    // One APB transfer; holds the request until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait as long as the slave needs; only the watchdog ends it
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask

    task wrap_up;
        $display("fails=%0d compares=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Producer: notes each accepted word, holds it while stalled
    always @(posedge clk) begin
        if (nrst && wr_en && wr_ready) q.push_back(wr_data);
        if (!nrst) wr_en <= 1'b0;
        else if (!wr_en || wr_ready) begin
            wr_en <= ($urandom % 4) < prate;
            wr_data <= $urandom;
        end
    end

    // Consumer pace
    always @(posedge clk) go <= ($urandom % 4) < crate;

    // Each pop must show the oldest noted word
    always @(posedge clk) begin
        if (!nrst) q.delete();
        else if (rd_en === 1'b1 && q.size() == 0) chk(32'h0, 32'h1);
        else if (rd_en === 1'b1) chk(rd_data, q.pop_front());
    end

    // Second build producer, same pace, holds its word while stalled
    always @(posedge clk) begin
        if (nrst && b_wr_en && b_rdy) bq.push_back(b_data);
        if (!nrst) b_wr_en <= 1'b0;
        else if (!b_wr_en || b_rdy) begin
            b_wr_en <= ($urandom % 4) < prate;
            b_data  <= $urandom;
        end
    end

    // Registered read: the popped word stands after the popping edge
    always @(posedge clk) begin
        if (!nrst) begin
            bq.delete();
            b_pend <= 1'b0;
        end else begin
            if (b_pend) chk(b_rd_data, b_exp);
            b_pend <= (b_rd_en === 1'b1);
            if (b_rd_en === 1'b1 && bq.size() == 0) chk(32'h0, 32'h1);
            else if (b_rd_en === 1'b1) b_exp <= bq.pop_front();
        end
    end

    // Watchdog well past the expected run
    initial begin
        #100us;
        fails++;
        wrap_up;
    end

    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'h95D9A126));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(rd_level), 32'h0);
        chk(32'(wr_level), 32'h10);
        chk(32'(b_wl), 32'h10);
        rdc(`GDCF_CTRL_OFS, 32'h0, 1'b0);
        rdc(`GDCF_STATUS_OFS, 32'h9, 1'b0);
        rdc(`GDCF_LEVELS_OFS, 32'h0010_0000, 1'b0);
        apb(1'b1, `GDCF_STATUS_OFS, 32'hFFFF_FFFF);
        rdc(`GDCF_STATUS_OFS, 32'h9, 1'b0);
        rdc(12'h00C, 32'h0, 1'b1);
        // Hold the drain: buffer fills and refuses
        apb(1'b1, `GDCF_CTRL_OFS, 32'h1);
        prate <= 4;
        repeat (8) @(posedge clk);
        chk(32'(wr_ready), 32'h0);
        rdc(`GDCF_STATUS_OFS, 32'h5, 1'b0);
        apb(1'b1, `GDCF_CTRL_OFS, 32'h0);
        repeat (60) begin
            @(posedge clk);
            if (wr_full === 1'b1) break;
        end
        chk(32'(wr_full), 32'h1);
        repeat (4) @(posedge clk);
        chk(32'(wr_level), 32'h0);
        chk(32'(rd_level), 32'h10);
        rdc(`GDCF_STATUS_OFS, 32'h6, 1'b0);
        // Slow consumer drains it empty
        prate <= 0;
        crate <= 2;
        repeat (400) begin
            @(posedge clk);
            if (q.size() == 0 && rd_empty === 1'b1) break;
        end
        chk(32'(rd_empty), 32'h1);
        repeat (4) @(posedge clk);
        chk(32'(rd_level), 32'h0);
        chk(32'(wr_level), 32'h10);
        prate <= 2;
        crate <= 3;
        repeat (300) @(posedge clk);
        // Second reset in mid traffic
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(rd_empty), 32'h1);
        chk(32'(b_empty), 32'h1);
        chk(32'(wr_level), 32'h10);
        prate <= 3;
        crate <= 1;
        repeat (200) @(posedge clk);
        prate <= 0;
        crate <= 4;
        repeat (100) @(posedge clk);
        chk(q.size(), 32'h0);
        chk(bq.size(), 32'h0);
        chk(32'(b_rl), 32'h0);
        chk(32'(b_wl), 32'h10);
        wrap_up;
    end
endmodule
